// ===== logic/ext_irq_pkg.sv
// constants and types shared by the external interrupt pin controller
package ext_irq_pkg;

  localparam int NUM_CH = 4;

  // channel order inside the block
  localparam int CH_ONE   = 0;
  localparam int CH_NMI   = 1;
  localparam int CH_TWO   = 2;
  localparam int CH_THREE = 3;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EXT_IRQ1_CONTROL        = 16'h7070;
  localparam logic [15:0] IDX_NONMASKABLE_PIN_CONTROL = 16'h7072;
  localparam logic [15:0] IDX_EXT_IRQ2_CONTROL        = 16'h7078;
  localparam logic [15:0] IDX_EXT_IRQ3_CONTROL        = 16'h707a;
  localparam logic [15:0] IDX_IRQ_STATUS              = 16'h7080;
  localparam logic [15:0] IDX_IRQ_MASK                = 16'h7081;

  localparam logic [NUM_CH-1:0][15:0] CTRL_IDX = {
    IDX_EXT_IRQ3_CONTROL, IDX_EXT_IRQ2_CONTROL,
    IDX_NONMASKABLE_PIN_CONTROL, IDX_EXT_IRQ1_CONTROL};

  // field positions inside a control register
  localparam int FLAG_BIT   = 15;
  localparam int LEVEL_BIT  = 6;
  localparam int NMISEL_BIT = 5;
  localparam int DIR_BIT    = 4;
  localparam int DOUT_BIT   = 3;
  localparam int POL_BIT    = 2;
  localparam int PRIO_BIT   = 1;
  localparam int EN_BIT     = 0;

  // which channels implement which optional fields
  localparam logic [NUM_CH-1:0] HAS_PRIO_EN = 4'b1101;
  localparam logic [NUM_CH-1:0] HAS_GPIO    = 4'b1100;
  localparam logic [NUM_CH-1:0] HAS_NMISEL  = 4'b0001;
  localparam logic [NUM_CH-1:0] FIXED_NMI   = 4'b0010;

  // pin edge detector needs this many samples before it may report
  localparam int ARM_CYCLES = 3;

  typedef struct packed {
    logic flag;
    logic nmisel;
    logic dir;
    logic dout;
    logic pol;
    logic prio;
    logic en;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;
  localparam logic [NUM_CH-1:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// ===== logic/pin_edge_detect.sv
// synchroniser and selected-edge detector for one interrupt pin
`timescale 1ns/1ns
`default_nettype none
module pin_edge_detect (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic pol_i,
  output logic      level_o,
  output logic      edge_o
);

  logic                                meta_r;
  logic                                sync_r;
  logic                                prev_r;
  logic [ext_irq_pkg::ARM_CYCLES-1:0]  arm_r;

  // two-flop synchroniser, then one more sample for comparison
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // no edge reported until real samples fill the pipe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_r <= '0;
    end else begin
      arm_r <= {arm_r[ext_irq_pkg::ARM_CYCLES-2:0], 1'b1};
    end
  end

  assign level_o = sync_r;
  assign edge_o  = arm_r[ext_irq_pkg::ARM_CYCLES-1] && (sync_r != prev_r)
                   && (sync_r == pol_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_edge_from_samples;
    edge_o |-> (level_o != $past(level_o));
  endproperty
  a_edge_from_samples: assert property (p_edge_from_samples)
    else $error("edge reported without a change between samples");

  property p_edge_polarity;
    edge_o |-> (level_o == pol_i);
  endproperty
  a_edge_polarity: assert property (p_edge_polarity)
    else $error("edge reported in the wrong direction");

endmodule
`default_nettype wire

// ===== logic/ext_irq_ctrl.sv
// external interrupt pin controller with its register slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ext_irq_ctrl (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [17:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        EXT_IRQ_PIN_ONE_I,
  input  wire logic        NMI_PIN_I,
  input  wire logic        EXT_IRQ_PIN_TWO_I,
  output logic             EXT_IRQ_PIN_TWO_O,
  output logic             EXT_IRQ_PIN_TWO_OE_O,
  input  wire logic        EXT_IRQ_PIN_THREE_I,
  output logic             EXT_IRQ_PIN_THREE_O,
  output logic             EXT_IRQ_PIN_THREE_OE_O,
  input  wire logic        ACK_HI_I,
  input  wire logic        ACK_LO_I,
  input  wire logic        ACK_NMI_I,
  output logic             INT_HI_O,
  output logic             INT_LO_O,
  output logic             INT_NMI_O,
  output logic             IRQ_O
);

  localparam int N = ext_irq_pkg::NUM_CH;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ext_irq_pkg::bus_state_t bus_st_r;
  logic                    waitreq_r;
  logic [31:0]             rdata_r;
  logic [31:0]             rd_val;
  logic                    req;
  logic                    wr_acc;
  logic                    aligned;
  logic [15:0]             idx;
  logic [N-1:0]            sel;
  logic                    sel_stat;
  logic                    sel_mask;

  ext_irq_pkg::ctrl_t      ctrl_r [N];
  logic [N-1:0][15:0]      ctrl_word;
  logic [N-1:0]            pins_in;
  logic [N-1:0]            lvl;
  logic [N-1:0]            ch_edge;
  logic [N-1:0]            clr_wr;
  logic [N-1:0]            route_nmi;
  logic [N-1:0]            route_hi;
  logic [N-1:0]            route_lo;
  logic [N-1:0]            req_en;
  logic [N-1:0]            ack_ch;
  logic [N-1:0]            pend_r;
  logic [N-1:0]            pend_nxt;

  logic [N-1:0]            stat_r;
  logic [N-1:0]            stat_nxt;
  logic [N-1:0]            mask_r;
  logic                    int_hi_r;
  logic                    int_lo_r;
  logic                    int_nmi_r;
  logic                    irq_r;
  logic                    two_out_r;
  logic                    two_oe_r;
  logic                    three_out_r;
  logic                    three_oe_r;

  assign pins_in = {EXT_IRQ_PIN_THREE_I, EXT_IRQ_PIN_TWO_I, NMI_PIN_I, EXT_IRQ_PIN_ONE_I};

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops one cycle after the request

  assign req     = AVS_READ_I || AVS_WRITE_I;
  assign idx     = AVS_ADDRESS_I[17:2];
  assign aligned = (AVS_ADDRESS_I[1:0] == 2'b00);
  assign wr_acc  = AVS_WRITE_I && (bus_st_r == ext_irq_pkg::BUS_ACK);
  assign sel_stat = aligned && (idx == ext_irq_pkg::IDX_IRQ_STATUS);
  assign sel_mask = aligned && (idx == ext_irq_pkg::IDX_IRQ_MASK);

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bus_st_r  <= ext_irq_pkg::BUS_IDLE;
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
    end else begin
      unique case (bus_st_r)
        ext_irq_pkg::BUS_IDLE: begin
          if (req) begin
            bus_st_r  <= ext_irq_pkg::BUS_ACK;
            waitreq_r <= 1'b0;
            rdata_r   <= AVS_READ_I ? rd_val : 32'h0000_0000;
          end
        end
        ext_irq_pkg::BUS_ACK: begin
          bus_st_r  <= ext_irq_pkg::BUS_IDLE;
          waitreq_r <= 1'b1;
        end
      endcase
    end
  end

  // reserved bits and unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int k = 0; k < N; k++) begin
      if (sel[k]) begin
        rd_val[15:0] = ctrl_word[k];
      end
    end
    if (sel_stat) begin
      rd_val[N-1:0] = stat_r;
    end
    if (sel_mask) begin
      rd_val[N-1:0] = mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per pin: detector, control register, pending request

  for (genvar k = 0; k < N; k++) begin : g_ch
    assign sel[k] = aligned && (idx == ext_irq_pkg::CTRL_IDX[k]);
    assign clr_wr[k] = wr_acc && sel[k] && AVS_BYTEENABLE_I[1]
                       && AVS_WRITEDATA_I[ext_irq_pkg::FLAG_BIT];

    pin_edge_detect pin_edge_detect_i (
      .clk_i   (MCLK_I),
      .rst_n_i (RESET_N_I),
      .pin_i   (pins_in[k]),
      .pol_i   (ctrl_r[k].pol),
      .level_o (lvl[k]),
      .edge_o  (ch_edge[k])
    );

    // flag: set wins over a clear in the same cycle
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        ctrl_r[k].flag <= ext_irq_pkg::CTRL_RESET.flag;
      end else if (ch_edge[k]) begin
        ctrl_r[k].flag <= 1'b1;
      end else if (clr_wr[k]) begin
        ctrl_r[k].flag <= 1'b0;
      end
    end

    // low byte settings; absent fields stay zero, bits 14..7 are dropped
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        ctrl_r[k].nmisel <= ext_irq_pkg::CTRL_RESET.nmisel;
        ctrl_r[k].dir    <= ext_irq_pkg::CTRL_RESET.dir;
        ctrl_r[k].dout   <= ext_irq_pkg::CTRL_RESET.dout;
        ctrl_r[k].pol    <= ext_irq_pkg::CTRL_RESET.pol;
        ctrl_r[k].prio   <= ext_irq_pkg::CTRL_RESET.prio;
        ctrl_r[k].en     <= ext_irq_pkg::CTRL_RESET.en;
      end else if (wr_acc && sel[k] && AVS_BYTEENABLE_I[0]) begin
        ctrl_r[k].pol    <= AVS_WRITEDATA_I[ext_irq_pkg::POL_BIT];
        ctrl_r[k].prio   <= AVS_WRITEDATA_I[ext_irq_pkg::PRIO_BIT]
                            && ext_irq_pkg::HAS_PRIO_EN[k];
        ctrl_r[k].en     <= AVS_WRITEDATA_I[ext_irq_pkg::EN_BIT]
                            && ext_irq_pkg::HAS_PRIO_EN[k];
        ctrl_r[k].dir    <= AVS_WRITEDATA_I[ext_irq_pkg::DIR_BIT]
                            && ext_irq_pkg::HAS_GPIO[k];
        ctrl_r[k].dout   <= AVS_WRITEDATA_I[ext_irq_pkg::DOUT_BIT]
                            && ext_irq_pkg::HAS_GPIO[k];
        ctrl_r[k].nmisel <= AVS_WRITEDATA_I[ext_irq_pkg::NMISEL_BIT]
                            && ext_irq_pkg::HAS_NMISEL[k];
      end
    end

    always_comb begin
      ctrl_word[k] = 16'h0000;
      ctrl_word[k][ext_irq_pkg::FLAG_BIT]   = ctrl_r[k].flag;
      ctrl_word[k][ext_irq_pkg::LEVEL_BIT]  = lvl[k];
      ctrl_word[k][ext_irq_pkg::NMISEL_BIT] = ctrl_r[k].nmisel;
      ctrl_word[k][ext_irq_pkg::DIR_BIT]    = ctrl_r[k].dir;
      ctrl_word[k][ext_irq_pkg::DOUT_BIT]   = ctrl_r[k].dout;
      ctrl_word[k][ext_irq_pkg::POL_BIT]    = ctrl_r[k].pol;
      ctrl_word[k][ext_irq_pkg::PRIO_BIT]   = ctrl_r[k].prio;
      ctrl_word[k][ext_irq_pkg::EN_BIT]     = ctrl_r[k].en;
    end

    // nonmaskable routing overrides priority and enable
    assign route_nmi[k] = ext_irq_pkg::FIXED_NMI[k] || ctrl_r[k].nmisel;
    assign route_hi[k]  = !route_nmi[k] && !ctrl_r[k].prio;
    assign route_lo[k]  = !route_nmi[k] && ctrl_r[k].prio;
    assign req_en[k]    = route_nmi[k] || ctrl_r[k].en;
    assign ack_ch[k]    = (route_nmi[k] && ACK_NMI_I) || (route_hi[k] && ACK_HI_I)
                          || (route_lo[k] && ACK_LO_I);
    // each edge re-raises the request regardless of the flag
    assign pend_nxt[k]  = (ch_edge[k] && req_en[k])
                          || (pend_r[k] && !clr_wr[k] && !ack_ch[k]);
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // requests to the cpu levels

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      int_hi_r  <= 1'b0;
      int_lo_r  <= 1'b0;
      int_nmi_r <= 1'b0;
    end else begin
      int_hi_r  <= |(pend_nxt & route_hi);
      int_lo_r  <= |(pend_nxt & route_lo);
      int_nmi_r <= |(pend_nxt & route_nmi);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt line

  assign stat_nxt = ch_edge | (stat_r & ~((sel_stat && wr_acc && AVS_BYTEENABLE_I[0])
                                          ? AVS_WRITEDATA_I[N-1:0] : {N{1'b0}}));

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stat_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mask_r <= ext_irq_pkg::IRQ_MASK_RESET;
    end else if (sel_mask && wr_acc && AVS_BYTEENABLE_I[0]) begin
      mask_r <= AVS_WRITEDATA_I[N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital output pins; driven only while not enabled as interrupt

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      two_out_r   <= 1'b0;
      two_oe_r    <= 1'b0;
      three_out_r <= 1'b0;
      three_oe_r  <= 1'b0;
    end else begin
      two_out_r   <= ctrl_r[ext_irq_pkg::CH_TWO].dout;
      two_oe_r    <= ctrl_r[ext_irq_pkg::CH_TWO].dir
                     && !ctrl_r[ext_irq_pkg::CH_TWO].en;
      three_out_r <= ctrl_r[ext_irq_pkg::CH_THREE].dout;
      three_oe_r  <= ctrl_r[ext_irq_pkg::CH_THREE].dir
                     && !ctrl_r[ext_irq_pkg::CH_THREE].en;
    end
  end

  assign AVS_READDATA_O         = rdata_r;
  assign AVS_WAITREQUEST_O      = waitreq_r;
  assign EXT_IRQ_PIN_TWO_O      = two_out_r;
  assign EXT_IRQ_PIN_TWO_OE_O   = two_oe_r;
  assign EXT_IRQ_PIN_THREE_O    = three_out_r;
  assign EXT_IRQ_PIN_THREE_OE_O = three_oe_r;
  assign INT_HI_O               = int_hi_r;
  assign INT_LO_O               = int_lo_r;
  assign INT_NMI_O              = int_nmi_r;
  assign IRQ_O                  = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  property p_flag_on_edge;
    ch_edge[0] |=> ctrl_r[0].flag;
  endproperty
  a_flag_on_edge: assert property (p_flag_on_edge)
    else $error("flag not set by selected edge");

  property p_flag_clear_cause;
    $fell(ctrl_r[2].flag) |-> $past(clr_wr[2]);
  endproperty
  a_flag_clear_cause: assert property (p_flag_clear_cause)
    else $error("flag cleared without a software clear");

  property p_request_each_edge;
    (ch_edge[0] && ctrl_r[0].en && ctrl_r[0].flag && !ctrl_r[0].nmisel)
      |=> pend_r[0] ##0 (INT_HI_O || INT_LO_O);
  endproperty
  a_request_each_edge: assert property (p_request_each_edge)
    else $error("edge with flag already set raised no request");

  property p_clear_withdraws;
    (clr_wr[0] && !ch_edge[0]) |=> !pend_r[0] ##0 !(INT_HI_O && route_hi[0] && !(|pend_r));
  endproperty
  a_clear_withdraws: assert property (p_clear_withdraws)
    else $error("software clear left the request pending");

  property p_level_readback;
    (req && !AVS_WRITE_I && bus_st_r == ext_irq_pkg::BUS_IDLE && sel[3])
      |=> AVS_READDATA_O[ext_irq_pkg::LEVEL_BIT] == $past(lvl[3]);
  endproperty
  a_level_readback: assert property (p_level_readback)
    else $error("pin level bit does not follow the pin");

  property p_priority_route;
    (pend_r[0] && !ctrl_r[0].prio && !ctrl_r[0].nmisel && $stable(ctrl_r[0].prio)
      && $stable(ctrl_r[0].nmisel)) |-> INT_HI_O;
  endproperty
  a_priority_route: assert property (p_priority_route)
    else $error("high priority request not on the high level");

  property p_disabled_no_request;
    (ch_edge[3] && !ctrl_r[3].en && !pend_r[3]) |=> !pend_r[3];
  endproperty
  a_disabled_no_request: assert property (p_disabled_no_request)
    else $error("disabled pin raised a request");

  property p_nmi_select;
    (ch_edge[0] && ctrl_r[0].nmisel && !ctrl_r[0].en) |=> (INT_NMI_O && !INT_HI_O)[*1];
  endproperty
  a_nmi_select: assert property (p_nmi_select)
    else $error("pin one in nonmaskable mode did not reach the nonmaskable level");

  property p_dedicated_reserved;
    ctrl_word[1][1:0] == 2'b00;
  endproperty
  a_dedicated_reserved: assert property (p_dedicated_reserved)
    else $error("nonmaskable pin reserved bits not zero");

  property p_output_enable;
    (ctrl_r[2].dir && !ctrl_r[2].en) |=> EXT_IRQ_PIN_TWO_OE_O;
  endproperty
  a_output_enable: assert property (p_output_enable)
    else $error("pin two not driven as digital output");

endmodule
`default_nettype wire

// ===== tb/irq_far_side.sv
// far side model: interrupt source pins and cpu acknowledge levels
`timescale 1ns/1ns
`default_nettype none
module irq_far_side (
  input  wire logic       clk_i,
  output logic      [3:0] pin_o,
  output logic      [2:0] ack_o
);
  initial begin
    pin_o = 4'h0;
    ack_o = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one pin change, then enough quiet cycles for the request to land
  task automatic set_pin(input int ch, input logic val);
    @(posedge clk_i);
    pin_o[ch] <= val;
    repeat (6) @(posedge clk_i);
  endtask

  // cpu answers one level after dly cycles with a one-cycle pulse
  task automatic ack(input int lvl, input int dly);
    repeat (dly) @(posedge clk_i);
    @(posedge clk_i);
    ack_o[lvl] <= 1'b1;
    @(posedge clk_i);
    ack_o <= 3'h0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/ext_irq_ctrl_tb.sv
// self-checking bench for the external interrupt pin controller
`timescale 1ns/1ns
`default_nettype none
module ext_irq_ctrl_tb;
  logic        MCLK_I;
  logic        RESET_N_I;
  logic [17:0] AVS_ADDRESS_I;
  logic        AVS_READ_I;
  logic        AVS_WRITE_I;
  logic [31:0] AVS_WRITEDATA_I;
  logic [3:0]  AVS_BYTEENABLE_I;
  logic [31:0] AVS_READDATA_O;
  logic        AVS_WAITREQUEST_O;
  logic [3:0]  pin;
  logic [2:0]  ack;
  logic        o2, oe2, o3, oe3;
  logic        INT_HI_O, INT_LO_O, INT_NMI_O, IRQ_O;
  int          failures;
  int          checks_done;
  wire logic [15:0] ints = {12'h000, IRQ_O, INT_NMI_O, INT_LO_O, INT_HI_O};

  initial begin
    MCLK_I = 1'b0;
    RESET_N_I = 1'b0;
    AVS_ADDRESS_I = 18'h0_0000;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_WRITEDATA_I = 32'h0000_0000;
    AVS_BYTEENABLE_I = 4'h0;
    failures = 0;
    checks_done = 0;
  end
  always #10 MCLK_I = ~MCLK_I;

  irq_far_side irq_far_side_i (.clk_i(MCLK_I), .pin_o(pin), .ack_o(ack));

  ext_irq_ctrl ext_irq_ctrl_i (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .EXT_IRQ_PIN_ONE_I(pin[0]), .NMI_PIN_I(pin[1]),
    .EXT_IRQ_PIN_TWO_I(oe2 ? o2 : pin[2]), .EXT_IRQ_PIN_TWO_O(o2),
    .EXT_IRQ_PIN_TWO_OE_O(oe2), .EXT_IRQ_PIN_THREE_I(oe3 ? o3 : pin[3]),
    .EXT_IRQ_PIN_THREE_O(o3), .EXT_IRQ_PIN_THREE_OE_O(oe3), .ACK_HI_I(ack[0]),
    .ACK_LO_I(ack[1]), .ACK_NMI_I(ack[2]), .INT_HI_O(INT_HI_O), .INT_LO_O(INT_LO_O),
    .INT_NMI_O(INT_NMI_O), .IRQ_O(IRQ_O));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [15:0] idx, input logic [15:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge MCLK_I);
    AVS_ADDRESS_I <= {idx, 2'b00};
    AVS_WRITEDATA_I <= {16'h0000, wd};
    AVS_BYTEENABLE_I <= be;
    AVS_READ_I <= !is_wr;
    AVS_WRITE_I <= is_wr;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 20);
    rd = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    if (AVS_WAITREQUEST_O !== 1'b0) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] be);
    logic [31:0] r;
    bus(1'b1, idx, d, be, r);
    repeat (2) @(posedge MCLK_I);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 16'h0000, 4'hf, r);
    checks_done++;
    if (r !== {16'h0000, exp}) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, r, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int ch = 0; ch < 4; ch++) begin
      rd_chk(ext_irq_pkg::CTRL_IDX[ch], 16'h0000);
    end
    rd_chk(ext_irq_pkg::IDX_IRQ_STATUS, 16'h0000);
    rd_chk(ext_irq_pkg::IDX_IRQ_MASK, 16'h0000);
    rd_chk(16'h0000, 16'h0000);
    chk(ints, 16'h0000);
  endtask

  task automatic t_edge_req();
    wr(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h0005, 4'h3);
    irq_far_side_i.set_pin(0, 1'b1);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h8045);
    chk(ints, 16'h0001);
    irq_far_side_i.ack(0, 2);
    chk(ints, 16'h0000);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h8045);
    irq_far_side_i.set_pin(0, 1'b0);
    chk(ints, 16'h0000);
    irq_far_side_i.set_pin(0, 1'b1);
    chk(ints, 16'h0001);
    wr(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h8000, 4'h2);
    chk(ints, 16'h0000);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h0045);
  endtask

  task automatic t_pol_prio();
    wr(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h0003, 4'h3);
    irq_far_side_i.set_pin(2, 1'b1);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h0043);
    irq_far_side_i.set_pin(2, 1'b0);
    chk(ints, 16'h0002);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h8003);
    irq_far_side_i.ack(1, 0);
    chk(ints, 16'h0000);
    wr(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h8000, 4'h2);
  endtask

  task automatic t_nmi();
    wr(ext_irq_pkg::IDX_EXT_IRQ1_CONTROL, 16'h0022, 4'h3);
    irq_far_side_i.set_pin(0, 1'b0);
    chk(ints, 16'h0004);
    irq_far_side_i.ack(2, 1);
    chk(ints, 16'h0000);
    wr(ext_irq_pkg::IDX_NONMASKABLE_PIN_CONTROL, 16'h0007, 4'h3);
    rd_chk(ext_irq_pkg::IDX_NONMASKABLE_PIN_CONTROL, 16'h0004);
    irq_far_side_i.set_pin(1, 1'b1);
    chk(ints, 16'h0004);
    irq_far_side_i.ack(2, 3);
    chk(ints, 16'h0000);
  endtask

  task automatic t_disabled();
    wr(ext_irq_pkg::IDX_IRQ_STATUS, 16'h000f, 4'h1);
    wr(ext_irq_pkg::IDX_EXT_IRQ3_CONTROL, 16'h0004, 4'h3);
    irq_far_side_i.set_pin(3, 1'b1);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ3_CONTROL, 16'h8044);
    chk(ints, 16'h0000);
    rd_chk(ext_irq_pkg::IDX_IRQ_STATUS, 16'h0008);
    wr(ext_irq_pkg::IDX_IRQ_MASK, 16'h0008, 4'h1);
    chk(ints, 16'h0008);
    wr(ext_irq_pkg::IDX_IRQ_STATUS, 16'h0008, 4'h1);
    chk(ints, 16'h0000);
  endtask

  task automatic t_gpio();
    wr(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h7f98, 4'h3);
    chk({14'h0000, oe2, o2}, 16'h0003);
    rd_chk(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h0058);
    wr(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h0010, 4'h3);
    chk({14'h0000, oe2, o2}, 16'h0002);
    wr(ext_irq_pkg::IDX_EXT_IRQ2_CONTROL, 16'h001d, 4'h3);
    chk({15'h0000, oe2}, 16'h0000);
    wr(ext_irq_pkg::IDX_EXT_IRQ3_CONTROL, 16'h0018, 4'h3);
    chk({14'h0000, oe3, o3}, 16'h0003);
    wr(ext_irq_pkg::IDX_EXT_IRQ3_CONTROL, 16'h0019, 4'h3);
    chk({15'h0000, oe3}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge MCLK_I);
    RESET_N_I <= 1'b1;
    t_reset();
    t_edge_req();
    t_pol_prio();
    t_nmi();
    t_disabled();
    t_gpio();
    finish_test();
  end
endmodule
`default_nettype wire
